// *** common/asc_params.svh ***
/*
 * Offsets, field layouts, reset values and timing counts of the error
 * severity and correctable status register bank.
 * Assumes 32-bit registers, one aligned word each, on a byte-addressed bus.
 */
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// Byte offsets of the registers.
`define ASC_OFF_UNCOR_SEV 12'h10c
`define ASC_OFF_COR_STATUS 12'h110
`define ASC_OFF_INT_STATUS 12'h130
`define ASC_OFF_INT_MASK 12'h134

// Severity field positions.
`define ASC_SEV_UNUSED_LEGACY 0
`define ASC_SEV_LINK_PROTOCOL 4
`define ASC_SEV_SURPRISE_DOWN 5
`define ASC_SEV_POISONED 12
`define ASC_SEV_FLOW_CREDIT 13
`define ASC_SEV_COMPLETION_TIMEOUT 14
`define ASC_SEV_COMPLETER_ABORT 15
`define ASC_SEV_UNEXPECTED_CPL 16
`define ASC_SEV_RECEIVER_OVERFLOW 17
`define ASC_SEV_MALFORMED 18
`define ASC_SEV_ECRC 19
`define ASC_SEV_UNSUPPORTED_REQ 20

// Correctable status field positions.
`define ASC_COR_RECEIVER_ERROR 0
`define ASC_COR_BAD_TRANSACTION_PACKET 6
`define ASC_COR_BAD_LINK_PACKET 7
`define ASC_COR_REPLAY_ROLLOVER 8
`define ASC_COR_REPLAY_TIMER 12
`define ASC_COR_ADVISORY_NONFATAL 13

// Writable bits, error types in use, and reset values.
`define ASC_SEV_WRITE_MASK 32'h001f3031
`define ASC_SEV_IMPL_MASK 32'h001f3030
`define ASC_SEV_RESET 32'h00062030
`define ASC_COR_VALID_MASK 32'h000031c1
`define ASC_COR_RESET 32'h00000000

// Interrupt status and mask layout.
`define ASC_INT_FATAL 0
`define ASC_INT_NONFATAL 1
`define ASC_INT_CORRECTABLE 2
`define ASC_INT_VALID_MASK 32'h00000007
`define ASC_INT_MASK_RESET 32'h00000000

// Bus answer latency in clock cycles after the request is complete.
`define ASC_BUS_LATENCY 1

`endif

// *** common/asc_pkg.sv ***
/*
 * Types shared by the error severity and correctable status bank.
 * Assumes nothing of its surroundings.
 */
package asc_pkg;

	// Bus response codes.
	typedef enum logic [1:0] {
		ASC_RESP_OKAY = 2'b00,
		ASC_RESP_SLVERR = 2'b10,
		ASC_RESP_DECERR = 2'b11
	} asc_resp_e;

	// One register word.
	typedef logic [31:0] asc_word_t;

endpackage

// *** rtl/asc_sticky_reg.sv ***
/*
 * A software-writable register with per-bit write mask and byte lanes.
 * Assumes the caller forms bit enables from byte strobes; only the
 * fundamental reset returns it to its reset value.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_sticky_reg #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] WRITE_MASK = '1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic wrEn,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [WIDTH-1:0] wrBits,
	output logic [WIDTH-1:0] value
);

	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;
	logic [WIDTH-1:0] takeBits;

	// Only enabled lanes of writable bits change; the rest hold.
	assign takeBits = wrEn ? (wrBits & WRITE_MASK) : '0;
	assign value_d = (value_q & ~takeBits) | (wrData & takeBits);
	assign value = value_q;

	// The register survives every reset but the fundamental one.
	always_ff @(posedge clock) begin
		if (srst) begin
			value_q <= RESET_VALUE;
		end else begin
			value_q <= value_d;
		end
	end

endmodule

`default_nettype wire

// *** rtl/asc_w1c_reg.sv ***
/*
 * A status register whose bits hardware sets and software clears.
 * Assumes set pulses come from logic on the same clock; a set in the
 * clearing cycle wins, so a clear never drops an event.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_w1c_reg #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] VALID_MASK = '1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0,
	parameter bit CLEAR_ON_HOT = 1'b0
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic hotRst,
	input wire logic [WIDTH-1:0] setBits,
	input wire logic [WIDTH-1:0] clrBits,
	output logic [WIDTH-1:0] value
);

	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;
	logic lostOnHot;

	// Set beats clear; reserved bits never hold a one.
	assign value_d = ((value_q & ~clrBits) | setBits) & VALID_MASK;
	assign lostOnHot = CLEAR_ON_HOT && hotRst;
	assign value = value_q;

	// Sticky flavour keeps its bits over a hot reset.
	always_ff @(posedge clock) begin
		if (srst || lostOnHot) begin
			value_q <= RESET_VALUE;
		end else begin
			value_q <= value_d;
		end
	end

endmodule

`default_nettype wire

// *** rtl/asc_err_bank.sv ***
/*
 * Uncorrectable error severity and correctable error status registers of
 * a switch port's advanced error reporting block, with their report
 * logic, an AXI4-Lite register slave and a masked interrupt.
 * Assumes error events are one-cycle pulses from logic on the same clock,
 * and that the uncorrectable and correctable mask registers live outside
 * and are presented here as levels.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"

// Operation
// RL1: Unmasked implemented uncorrectable event reports fatal if severity one, else non-fatal.
// RL2: Severity applies only to unmasked events; masked events give no report.
// RL3: Severity bits 4,5,12,13,16-20 are writable sticky bits.
// RL4: Bits 4,5,13,17,18 reset to one; bits 12,16,19,20 reset to zero.
// RL5: Completion timeout severity bit 14 is read-only zero.
// RL6: Completer abort severity bit 15 is read-only zero.
// RL7: Severity bit 0 is writable sticky, resets zero, changes nothing.
// RL8: Correctable status bit 0 sets on a physical layer receiver error.
// RL9: Status bit 6 sets on a bad packet, bit 7 on a bad link packet.
// RL10: Status bit 8 sets when the replay number rolls over.
// RL11: Status bit 12 sets when the replay timer expires.
// RL12: Status bit 13 sets on an advisory non-fatal error.
// RL13: A masked uncorrectable event is neither logged nor reported.
// RL14: A masked correctable event is not reported, but its status still sets.
// RL15: Correctable status bits are sticky, reset zero, clear on writing one.
// RL16: Sticky bits survive hot resets and reset only on the fundamental reset.
module asc_err_bank #(
	parameter int ADDR_W = 12
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic hotRst,
	// Register bus.
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Uncorrectable events and the mask that gates them.
	input wire logic [31:0] uncorEvent,
	input wire logic [31:0] uncorMask,
	// Correctable events and the mask that gates their reports.
	input wire logic receiverError,
	input wire logic badTransactionPacket,
	input wire logic badLinkPacket,
	input wire logic replayNumberRollover,
	input wire logic replayTimerExpired,
	input wire logic advisoryNonfatalError,
	input wire logic [31:0] corMask,
	// Reports toward the root complex and the uncorrectable status log.
	output logic fatalReport,
	output logic nonFatalReport,
	output logic corReport,
	output logic [31:0] uncorLog,
	output logic irq
);

	// Refuse address widths too narrow to reach the top register or wider than the bus.
	if (ADDR_W < 9 || ADDR_W > 32) begin : g_badAddrW
		$error("asc_err_bank: ADDR_W must lie between 9 and 32.");
	end

	// Write channel state.
	logic awRdy_q;
	logic awHave_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic wRdy_q;
	logic wHave_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bValid_q;
	logic [1:0] bResp_q;

	// Read channel state.
	logic arRdy_q;
	logic rValid_q;
	logic [31:0] rData_q;
	logic [1:0] rResp_q;

	// Report outputs.
	logic fatal_q;
	logic nonFatal_q;
	logic cor_q;
	logic [31:0] uncorLog_q;
	logic irq_q;
	logic [31:0] intMask_q;

	// Register contents.
	logic [31:0] sevValue;
	logic [31:0] corValue;
	logic [31:0] intValue;

	// Handshake terms on each channel.
	wire awTake = awvalid && awRdy_q;
	wire wTake = wvalid && wRdy_q;
	wire bDone = bValid_q && bready;
	wire arTake = arvalid && arRdy_q;
	wire rDone = rValid_q && rready;

	// A write is carried out once address and data are both held and no answer waits.
	wire doWrite = awHave_q && wHave_q && !bValid_q;

	// Write address decode on the latched word address.
	wire [ADDR_W-1:0] wWord = {awAddr_q[ADDR_W-1:2], 2'b00};
	wire wrSev = doWrite && (wWord == ADDR_W'(`ASC_OFF_UNCOR_SEV));
	wire wrCor = doWrite && (wWord == ADDR_W'(`ASC_OFF_COR_STATUS));
	wire wrInt = doWrite && (wWord == ADDR_W'(`ASC_OFF_INT_STATUS));
	wire wrMask = doWrite && (wWord == ADDR_W'(`ASC_OFF_INT_MASK));
	wire wrHit = wrSev || wrCor || wrInt || wrMask;

	// Byte strobes widened to bit enables.
	wire [31:0] wrBits = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

	// Read address decode on the incoming address.
	wire [ADDR_W-1:0] rWord = {araddr[ADDR_W-1:2], 2'b00};
	wire rdSev = (rWord == ADDR_W'(`ASC_OFF_UNCOR_SEV));
	wire rdCor = (rWord == ADDR_W'(`ASC_OFF_COR_STATUS));
	wire rdInt = (rWord == ADDR_W'(`ASC_OFF_INT_STATUS));
	wire rdMask = (rWord == ADDR_W'(`ASC_OFF_INT_MASK));
	wire rdHit = rdSev || rdCor || rdInt || rdMask;

	// Read data selection; unmapped words read zero.
	wire [31:0] rdMux = rdSev ? sevValue :
		rdCor ? corValue :
		rdInt ? intValue :
		rdMask ? intMask_q : 32'h00000000;
	wire [1:0] rdResp = rdHit ? asc_pkg::ASC_RESP_OKAY : asc_pkg::ASC_RESP_DECERR;
	wire [1:0] wrResp = wrHit ? asc_pkg::ASC_RESP_OKAY : asc_pkg::ASC_RESP_DECERR;

	// Severity register; fixed zeros at 14 and 15 come from the write mask.
	asc_sticky_reg #(
		.WIDTH(32),
		.WRITE_MASK(`ASC_SEV_WRITE_MASK), // see RL3 see RL5 see RL6 see RL7
		.RESET_VALUE(`ASC_SEV_RESET) // see RL4
	) sevReg (
		.clock(clock),
		.srst(srst), // see RL16
		.wrEn(wrSev),
		.wrData(wData_q),
		.wrBits(wrBits),
		.value(sevValue)
	);

	// Correctable events gathered at their status positions.
	logic [31:0] corSet;
	always_comb begin
		corSet = 32'h00000000;
		corSet[`ASC_COR_RECEIVER_ERROR] = receiverError; // see RL8
		corSet[`ASC_COR_BAD_TRANSACTION_PACKET] = badTransactionPacket; // see RL9
		corSet[`ASC_COR_BAD_LINK_PACKET] = badLinkPacket; // see RL9
		corSet[`ASC_COR_REPLAY_ROLLOVER] = replayNumberRollover; // see RL10
		corSet[`ASC_COR_REPLAY_TIMER] = replayTimerExpired; // see RL11
		corSet[`ASC_COR_ADVISORY_NONFATAL] = advisoryNonfatalError; // see RL12
	end

	// A write of one clears a status bit; lanes not strobed are left alone.
	wire [31:0] corClr = wrCor ? (wData_q & wrBits) : 32'h00000000; // see RL15

	// Correctable status register, sticky across hot resets.
	asc_w1c_reg #(
		.WIDTH(32),
		.VALID_MASK(`ASC_COR_VALID_MASK),
		.RESET_VALUE(`ASC_COR_RESET),
		.CLEAR_ON_HOT(1'b0) // see RL16
	) corReg (
		.clock(clock),
		.srst(srst),
		.hotRst(hotRst),
		.setBits(corSet), // see RL14
		.clrBits(corClr), // see RL15
		.value(corValue)
	);

	// Uncorrectable events pass only when implemented and unmasked.
	wire [31:0] uncorLive = uncorEvent & ~uncorMask & `ASC_SEV_IMPL_MASK; // see RL2 see RL13
	wire fatalD = |(uncorLive & sevValue); // see RL1
	wire nonFatalD = |(uncorLive & ~sevValue); // see RL1
	wire corD = |(corSet & ~corMask & `ASC_COR_VALID_MASK); // see RL14

	// Interrupt events in status layout.
	logic [31:0] intSet;
	always_comb begin
		intSet = 32'h00000000;
		intSet[`ASC_INT_FATAL] = fatalD;
		intSet[`ASC_INT_NONFATAL] = nonFatalD;
		intSet[`ASC_INT_CORRECTABLE] = corD;
	end

	// Reading the interrupt status clears it; a same-cycle event survives.
	wire [31:0] intClr = (arTake && rdInt) ? 32'hffffffff : 32'h00000000;

	// Interrupt status, cleared by any reset.
	asc_w1c_reg #(
		.WIDTH(32),
		.VALID_MASK(`ASC_INT_VALID_MASK),
		.RESET_VALUE(32'h00000000),
		.CLEAR_ON_HOT(1'b1)
	) intReg (
		.clock(clock),
		.srst(srst),
		.hotRst(hotRst),
		.setBits(intSet),
		.clrBits(intClr),
		.value(intValue)
	);

	// Next value of the interrupt mask under byte strobes.
	wire [31:0] maskTake = wrMask ? (wrBits & `ASC_INT_VALID_MASK) : 32'h00000000;
	wire [31:0] intMask_d = (intMask_q & ~maskTake) | (wData_q & maskTake);

	// Interrupt mask register.
	always_ff @(posedge clock) begin
		if (srst || hotRst) begin
			intMask_q <= `ASC_INT_MASK_RESET;
		end else begin
			intMask_q <= intMask_d;
		end
	end

	// Report pulses and the status log strobe.
	always_ff @(posedge clock) begin
		if (srst || hotRst) begin
			fatal_q <= 1'b0;
			nonFatal_q <= 1'b0;
			cor_q <= 1'b0;
			uncorLog_q <= 32'h00000000;
		end else begin
			fatal_q <= fatalD; // see RL1
			nonFatal_q <= nonFatalD; // see RL1
			cor_q <= corD; // see RL14
			uncorLog_q <= uncorLive; // see RL13
		end
	end

	// Interrupt level, one cycle behind the status and mask registers.
	always_ff @(posedge clock) begin
		if (srst || hotRst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(intValue & intMask_q);
		end
	end

	// Write address channel: take once, reopen after the response.
	always_ff @(posedge clock) begin
		if (srst || hotRst) begin
			awRdy_q <= 1'b1;
			awHave_q <= 1'b0;
			awAddr_q <= '0;
		end else if (awTake) begin
			awRdy_q <= 1'b0;
			awHave_q <= 1'b1;
			awAddr_q <= awaddr;
		end else if (doWrite) begin
			awHave_q <= 1'b0;
		end else if (bDone) begin
			awRdy_q <= 1'b1;
		end
	end

	// Write data channel: take once, reopen after the response.
	always_ff @(posedge clock) begin
		if (srst || hotRst) begin
			wRdy_q <= 1'b1;
			wHave_q <= 1'b0;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
		end else if (wTake) begin
			wRdy_q <= 1'b0;
			wHave_q <= 1'b1;
			wData_q <= wdata;
			wStrb_q <= wstrb;
		end else if (doWrite) begin
			wHave_q <= 1'b0;
		end else if (bDone) begin
			wRdy_q <= 1'b1;
		end
	end

	// Write response, raised in the cycle after the write is done.
	always_ff @(posedge clock) begin
		if (srst || hotRst) begin
			bValid_q <= 1'b0;
			bResp_q <= asc_pkg::ASC_RESP_OKAY;
		end else if (doWrite) begin
			bValid_q <= 1'b1;
			bResp_q <= wrResp;
		end else if (bDone) begin
			bValid_q <= 1'b0;
		end
	end

	// Read channel: data and response captured when the address is taken.
	always_ff @(posedge clock) begin
		if (srst || hotRst) begin
			arRdy_q <= 1'b1;
			rValid_q <= 1'b0;
			rData_q <= 32'h00000000;
			rResp_q <= asc_pkg::ASC_RESP_OKAY;
		end else if (arTake) begin
			arRdy_q <= 1'b0;
			rValid_q <= 1'b1;
			rData_q <= rdMux;
			rResp_q <= rdResp;
		end else if (rDone) begin
			arRdy_q <= 1'b1;
			rValid_q <= 1'b0;
		end
	end

	// Write channel outputs, each straight from its flip-flop.
	assign awready = awRdy_q;
	assign wready = wRdy_q;
	assign bvalid = bValid_q;
	assign bresp = bResp_q;

	// Read channel outputs, each straight from its flip-flop.
	assign arready = arRdy_q;
	assign rvalid = rValid_q;
	assign rdata = rData_q;
	assign rresp = rResp_q;

	// Report and interrupt outputs, each straight from its flip-flop.
	assign fatalReport = fatal_q;
	assign nonFatalReport = nonFatal_q;
	assign corReport = cor_q;
	assign uncorLog = uncorLog_q;
	assign irq = irq_q;

endmodule

`default_nettype wire

// *** bench/asc_err_bank_asserts.sv ***
/*
 * Port checker for the error severity and correctable status bank.
 * Assumes one clock, with srst and hotRst both clearing the bus and report flops.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"

module asc_err_bank_asserts (
	input wire logic clock,
	input wire logic srst,
	input wire logic hotRst,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] uncorEvent,
	input wire logic [31:0] uncorMask,
	input wire logic receiverError,
	input wire logic badTransactionPacket,
	input wire logic badLinkPacket,
	input wire logic replayNumberRollover,
	input wire logic replayTimerExpired,
	input wire logic advisoryNonfatalError,
	input wire logic [31:0] corMask,
	input wire logic fatalReport,
	input wire logic nonFatalReport,
	input wire logic corReport,
	input wire logic [31:0] uncorLog
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst || hotRst);

	// Unmasked implemented uncorrectable events, and whether an unmasked correctable one came.
	wire logic [31:0] uncHit = uncorEvent & ~uncorMask & `ASC_SEV_IMPL_MASK;
	wire logic [5:0] corEv = {advisoryNonfatalError, replayTimerExpired, replayNumberRollover,
		badLinkPacket, badTransactionPacket, receiverError};
	wire logic [5:0] corOn = ~{corMask[13], corMask[12], corMask[8], corMask[7], corMask[6],
		corMask[0]};
	wire logic corHit = |(corEv & corOn);

	sequence s_wrTake; awvalid && awready && wvalid && wready; endsequence
	sequence s_wrAns; !bvalid ##1 bvalid; endsequence
	property p_wrAns; s_wrTake |=> s_wrAns; endproperty
	property p_wrHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	property p_rdAns; arvalid && arready |=> rvalid && !arready; endproperty
	property p_rdHold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	property p_uncRep; |uncHit |=> fatalReport || nonFatalReport; endproperty
	property p_uncQuiet; !(|uncHit) |=> !fatalReport && !nonFatalReport; endproperty
	property p_uncLog; 1'b1 |=> uncorLog == $past(uncHit); endproperty
	property p_corRep; corHit |=> corReport; endproperty
	property p_corQuiet; !corHit |=> !corReport; endproperty

	a_wrAns: assert property (p_wrAns) else $error("write answer late");
	a_wrHold: assert property (p_wrHold) else $error("write answer dropped");
	a_rdAns: assert property (p_rdAns) else $error("read answer late");
	a_rdHold: assert property (p_rdHold) else $error("read answer dropped");
	a_uncRep: assert property (p_uncRep) else $error("uncorrectable report missing");
	a_uncQuiet: assert property (p_uncQuiet) else $error("masked report seen");
	a_uncLog: assert property (p_uncLog) else $error("uncorrectable log wrong");
	a_corRep: assert property (p_corRep) else $error("correctable report missing");
	a_corQuiet: assert property (p_corQuiet) else $error("masked correctable report");
endmodule

bind asc_err_bank asc_err_bank_asserts u_asserts (
	.clock(clock), .srst(srst), .hotRst(hotRst), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.uncorEvent(uncorEvent), .uncorMask(uncorMask), .receiverError(receiverError),
	.badTransactionPacket(badTransactionPacket), .badLinkPacket(badLinkPacket),
	.replayNumberRollover(replayNumberRollover), .replayTimerExpired(replayTimerExpired),
	.advisoryNonfatalError(advisoryNonfatalError), .corMask(corMask),
	.fatalReport(fatalReport), .nonFatalReport(nonFatalReport), .corReport(corReport),
	.uncorLog(uncorLog));

`default_nettype wire

// *** bench/asc_root_model.sv ***
/*
 * Root complex stand-in that counts the error reports it receives.
 * Assumes each report is a one-cycle pulse on the bank's clock.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_root_model (
	input wire logic clock,
	input wire logic srst,
	input wire logic fatalReport,
	input wire logic nonFatalReport,
	input wire logic corReport,
	output logic [15:0] fatalSeen,
	output logic [15:0] nonFatalSeen,
	output logic [15:0] corSeen
);
	// Counts every report pulse by class; the fundamental reset starts over.
	always_ff @(posedge clock) begin
		if (srst) begin
			fatalSeen <= '0;
			nonFatalSeen <= '0;
			corSeen <= '0;
		end else begin
			fatalSeen <= fatalSeen + {15'h0, fatalReport};
			nonFatalSeen <= nonFatalSeen + {15'h0, nonFatalReport};
			corSeen <= corSeen + {15'h0, corReport};
		end
	end
endmodule

`default_nettype wire

// *** bench/tb.sv ***
/*
 * Self-checking bench for the error severity and correctable status bank.
 * Assumes the register map and reset values of the shared header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"

module tb;
	localparam logic [31:0] IMPL = `ASC_SEV_IMPL_MASK;
	localparam int COR_POS [6] = '{0, 6, 7, 8, 12, 13};
	logic clock = 1'b0, srst = 1'b1, hotRst = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, uncorEvent = '0, uncorMask = '0, corMask = '0, rv;
	logic [3:0] wstrb = '0;
	logic [5:0] corEv = '0;
	logic [1:0] rs;
	logic [15:0] expF = '0, expN = '0, expC = '0;
	wire logic awready, wready, bvalid, arready, rvalid, fatalReport, nonFatalReport;
	wire logic corReport, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata, uncorLog;
	wire logic [15:0] fatalSeen, nonFatalSeen, corSeen;
	int errTotal = 0, samplesChecked = 0;

	asc_err_bank #(.ADDR_W(12)) dut (.clock(clock), .srst(srst), .hotRst(hotRst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .uncorEvent(uncorEvent), .uncorMask(uncorMask),
		.receiverError(corEv[0]), .badTransactionPacket(corEv[1]), .badLinkPacket(corEv[2]),
		.replayNumberRollover(corEv[3]), .replayTimerExpired(corEv[4]),
		.advisoryNonfatalError(corEv[5]), .corMask(corMask), .fatalReport(fatalReport),
		.nonFatalReport(nonFatalReport), .corReport(corReport), .uncorLog(uncorLog), .irq(irq));

	asc_root_model rc (.clock(clock), .srst(srst), .fatalReport(fatalReport),
		.nonFatalReport(nonFatalReport), .corReport(corReport), .fatalSeen(fatalSeen),
		.nonFatalSeen(nonFatalSeen), .corSeen(corSeen));

	// Free-running bench clock.
	initial begin
		forever #12.5 clock = ~clock;
	end

	task automatic wrapUp;
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic guard(input int n);
		if (n > 60) begin
			errTotal++;
			wrapUp;
		end
	endtask

	// Write one word; each channel is released once taken, then one idle edge passes.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			guard(n);
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [11:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			guard(n);
		end while (!rvalid);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic pulseU(input logic [31:0] v);
		uncorEvent <= v;
		@(posedge clock);
		uncorEvent <= '0;
		repeat (2) @(posedge clock);
	endtask

	task automatic pulseC(input int i);
		corEv <= 6'h1 << i;
		@(posedge clock);
		corEv <= '0;
		repeat (2) @(posedge clock);
	endtask

	task automatic tResetVals;
		rd(`ASC_OFF_UNCOR_SEV);
		chk(rv, `ASC_SEV_RESET);
		chk({30'h0, rs}, {30'h0, asc_pkg::ASC_RESP_OKAY});
		rd(`ASC_OFF_COR_STATUS);
		chk(rv, `ASC_COR_RESET);
	endtask

	task automatic tSeverity;
		wr(`ASC_OFF_UNCOR_SEV, '1, 4'h1);
		rd(`ASC_OFF_UNCOR_SEV);
		chk(rv, (`ASC_SEV_RESET & 32'hffffff00) | (`ASC_SEV_WRITE_MASK & 32'h000000ff));
		wr(`ASC_OFF_UNCOR_SEV, '1, 4'hf);
		rd(`ASC_OFF_UNCOR_SEV);
		chk(rv, `ASC_SEV_WRITE_MASK);
	endtask

	// Every implemented type once as fatal, once as non-fatal, then masked.
	task automatic tUncor;
		for (int k = 0; k < 2; k++) begin
			if (k == 1) wr(`ASC_OFF_UNCOR_SEV, '0, 4'hf);
			for (int i = 0; i < 32; i++) begin
				if (IMPL[i]) begin
					pulseU(32'h1 << i);
					if (k == 0) expF++;
					else expN++;
				end
			end
		end
		pulseU(32'h0000c001);
		uncorMask <= IMPL;
		pulseU(IMPL);
		uncorMask <= '0;
		chk({16'h0, fatalSeen}, {16'h0, expF});
		chk({16'h0, nonFatalSeen}, {16'h0, expN});
	endtask

	task automatic tCor;
		for (int i = 0; i < 6; i++) begin
			pulseC(i);
			expC++;
			rd(`ASC_OFF_COR_STATUS);
			chk(rv, 32'h1 << COR_POS[i]);
			wr(`ASC_OFF_COR_STATUS, 32'h1 << COR_POS[i], 4'hf);
			rd(`ASC_OFF_COR_STATUS);
			chk(rv, '0);
		end
		corMask <= '1;
		pulseC(0);
		rd(`ASC_OFF_COR_STATUS);
		chk(rv, 32'h1);
		wr(`ASC_OFF_COR_STATUS, '0, 4'hf);
		rd(`ASC_OFF_COR_STATUS);
		chk(rv, 32'h1);
		wr(`ASC_OFF_COR_STATUS, '1, 4'hf);
		rd(`ASC_OFF_COR_STATUS);
		chk(rv, '0);
		corMask <= '0;
		chk({16'h0, corSeen}, {16'h0, expC});
	endtask

	// All three report classes have fired, so the interrupt waits only on its mask.
	task automatic tIrq;
		chk({31'h0, irq}, 32'h0);
		wr(`ASC_OFF_INT_MASK, 32'h7, 4'hf);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		rd(`ASC_OFF_INT_STATUS);
		chk(rv, 32'h7);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		wr(`ASC_OFF_INT_MASK, 32'h1, 4'hf);
		pulseC(0);
		chk({31'h0, irq}, 32'h0);
		rd(`ASC_OFF_INT_STATUS);
		chk(rv, 32'h4);
	endtask

	task automatic tReset;
		wr(`ASC_OFF_UNCOR_SEV, 32'h00100001, 4'hf);
		pulseC(0);
		hotRst <= 1'b1;
		repeat (2) @(posedge clock);
		hotRst <= 1'b0;
		rd(`ASC_OFF_UNCOR_SEV);
		chk(rv, 32'h00100001);
		rd(`ASC_OFF_COR_STATUS);
		chk(rv, 32'h1);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(`ASC_OFF_UNCOR_SEV);
		chk(rv, `ASC_SEV_RESET);
		rd(`ASC_OFF_COR_STATUS);
		chk(rv, '0);
		rd(12'h200);
		chk({30'h0, rs}, {30'h0, asc_pkg::ASC_RESP_DECERR});
		chk(rv, '0);
		wr(12'h200, '1, 4'hf);
		chk({30'h0, rs}, {30'h0, asc_pkg::ASC_RESP_DECERR});
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		tResetVals;
		tSeverity;
		tUncor;
		tCor;
		tIrq;
		tReset;
		wrapUp;
	end
endmodule

`default_nettype wire
